// ==== irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;
  // ----------------------------------------
  // source count and widths
  // ----------------------------------------
  localparam int          NUM_SRC      = 14;   // interrupt sources
  localparam int          IDX_W        = 4;    // source index width
  localparam int          ADDR_W       = 4;    // register address width
  localparam int          DATA_W       = 16;   // register data width
  localparam int          VEC_W        = 16;   // service address width
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0]  OFS_PEND     = 4'h0; // pending flags, write one to clear
  localparam logic [3:0]  OFS_PSET     = 4'h1; // pending flags, write one to set
  localparam logic [3:0]  OFS_PRIMARY  = 4'h2; // primary_irq_enable_reg
  localparam logic [3:0]  OFS_EXTENDED = 4'h3; // extended_irq_enable_reg
  localparam logic [3:0]  OFS_PRIO     = 4'h4; // priority level per source
  localparam logic [3:0]  OFS_HWCLR    = 4'h5; // auto clear on vector per source
  localparam logic [3:0]  OFS_STATE    = 4'h6; // service state, read only
  localparam logic [3:0]  OFS_EVT      = 4'h7; // sticky events, write one to clear
  localparam logic [3:0]  OFS_EVT_MASK = 4'h8; // event mask
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int          GLOBAL_BIT   = 7;    // global_irq_enable in primary reg
  localparam int          PRIMARY_SRC  = 7;    // sources held in primary reg
  localparam logic [15:0] HWCLR_RST    = 16'h000F; // first four sources clear on vector
  localparam logic [15:0] ZERO_RST     = 16'h0000;
  localparam int          EVT_W        = 2;
  localparam int          EVT_TAKEN    = 0;    // a vector was issued
  localparam int          EVT_RETURN   = 1;    // a return completed
  // ----------------------------------------
  // vector table: base plus eight per index
  // ----------------------------------------
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam int          VEC_STEP_SH  = 3;
  // ----------------------------------------
  // timing: one detect cycle, four for the call
  // ----------------------------------------
  localparam int          CALL_CYCLES  = 4;
  localparam int          MIN_RESPONSE = 5;
endpackage

// ==== irq_prio_pick.sv ====
`timescale 1ns/1ps
// fixed order pick: lowest index among a request vector wins
module irq_prio_pick #(
  parameter int N  = 14,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]  req_i,   // candidate requests
  output logic               any_o,   // some request present
  output logic [IW-1:0]      idx_o    // winner index
);
  // ----------------------------------------
  // scan from the top so index 0 lands last
  // ----------------------------------------
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end
endmodule

// ==== irq_sticky.sv ====
`timescale 1ns/1ps
// sticky flags: set wins over write-one-to-clear
module irq_sticky #(
  parameter int W = 2
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,   // hardware set pulses
  input  wire logic [W-1:0] clr_i,   // software clear bits
  output logic      [W-1:0] flag_o   // held flags
);
  // ----------------------------------------
  // set dominates a same cycle clear
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= (flag_o & ~clr_i) | set_i;
    end
  end
endmodule

// ==== irq_ctrl.sv ====
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int N = irq_ctrl_pkg::NUM_SRC
) (
  input  wire logic                              clock_i,
  input  wire logic                              rst_i,
  // register port
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [irq_ctrl_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [irq_ctrl_pkg::DATA_W-1:0]   rdata_o,
  // peripheral conditions, one-cycle pulses
  input  wire logic [N-1:0]                      src_event_i,
  // core sequencer side
  input  wire logic                              instr_end_i,
  input  wire logic                              instr_multi_i,
  input  wire logic                              return_done_i,
  output logic                                   irq_req_o,
  output logic                                   call_o,
  output logic      [irq_ctrl_pkg::VEC_W-1:0]    call_addr_o,
  output logic      [irq_ctrl_pkg::IDX_W-1:0]    call_idx_o,
  output logic                                   irq_o
);
  import irq_ctrl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,   // no call in flight
    ST_CALL = 3'b010,   // long call in progress
    ST_GAP  = 3'b100    // one instruction after a return
  } seq_type;

  seq_type          state;          // sequencer state
  seq_type          next_state;
  logic [N-1:0]     pending;        // pending flags
  logic [7:0]       primary_en;     // primary enable register
  logic [7:0]       extended_en;    // extended enable register
  logic [N-1:0]     prio;           // one = high level
  logic [N-1:0]     hwclr;          // auto clear on vector
  logic             in_low;         // low level routine active
  logic             in_high;        // high level routine active
  logic [2:0]       call_cnt;       // long call cycles left
  logic [IDX_W-1:0] call_idx;       // source being vectored
  logic             arm;            // request latched one cycle ago
  logic [EVT_W-1:0] evt_mask;
  logic [EVT_W-1:0] evt_flags;
  logic [N-1:0]     next_pending;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [N-1:0] src_en   = {extended_en[N-PRIMARY_SRC-1:0], primary_en[PRIMARY_SRC-1:0]};
  wire         glb_en   = primary_en[GLOBAL_BIT];
  wire [N-1:0] eligible = pending & src_en & {N{glb_en}};
  wire [N-1:0] hi_req   = eligible & prio;
  wire [N-1:0] lo_req   = eligible & ~prio;
  wire         wr_pend  = wr_i && (addr_i == OFS_PEND);
  wire         wr_pset  = wr_i && (addr_i == OFS_PSET);
  wire         wr_evt   = wr_i && (addr_i == OFS_EVT);
  wire         take_v;                // vector taken this cycle
  wire         hi_any;
  wire         lo_any;
  wire [IDX_W-1:0] hi_idx;
  wire [IDX_W-1:0] lo_idx;

  // fixed order within each level
  irq_prio_pick #(.N(N), .IW(IDX_W)) u_hi (
    .req_i (hi_req),
    .any_o (hi_any),
    .idx_o (hi_idx)
  );
  irq_prio_pick #(.N(N), .IW(IDX_W)) u_lo (
    .req_i (lo_req),
    .any_o (lo_any),
    .idx_o (lo_idx)
  );

  // high wins; nothing preempts high; low needs an idle core
  wire         hi_ok   = hi_any && !in_high;
  wire         lo_ok   = lo_any && !in_high && !in_low;
  wire         want    = hi_ok || lo_ok;
  wire [IDX_W-1:0] win = hi_ok ? hi_idx : lo_idx;
  wire         win_hi  = hi_ok;

  // request raised only after a detect cycle; the enable clear of the
  // previous instruction drops eligible, so a multi-cycle follower sees it
  assign irq_req_o = want && arm;
  // a single-cycle follower may still end while arm holds the old sample;
  // a multi-cycle one re-checks live eligibility at its end
  wire   arm_live  = instr_multi_i ? want : 1'b1;
  // no vector in the return cycle itself: the level pop would otherwise be lost
  // under the new call, and the gap state would override its ST_CALL
  assign take_v    = (state == ST_IDLE) && irq_req_o && instr_end_i && arm_live
                     && !return_done_i;

  // ----------------------------------------
  // detect register: sampled each clock
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      arm <= 1'b0;
    end else begin
      arm <= want;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_v) begin
          next_state = ST_CALL;
        end
      end
      ST_CALL: begin
        if (call_cnt == 3'd1) begin
          next_state = ST_IDLE;
        end
      end
      ST_GAP: begin
        // one whole instruction runs before any new vector
        if (instr_end_i) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (return_done_i) begin
      next_state = ST_GAP;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // call cycle counter and vector outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      call_cnt    <= '0;
      call_idx    <= '0;
      call_o      <= 1'b0;
      call_addr_o <= '0;
      call_idx_o  <= '0;
    end else begin
      call_o <= take_v;
      if (take_v) begin
        call_cnt    <= 3'(CALL_CYCLES);
        call_idx    <= win;
        call_idx_o  <= win;
        call_addr_o <= VEC_BASE + VEC_W'({win, VEC_STEP_SH'(0)});
      end else if (call_cnt != 3'd0) begin
        call_cnt <= call_cnt - 3'd1;
      end
    end
  end

  // ----------------------------------------
  // active level tracking
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      in_low  <= 1'b0;
      in_high <= 1'b0;
    end else if (take_v) begin
      if (win_hi) begin
        in_high <= 1'b1;
      end else begin
        in_low  <= 1'b1;
      end
    end else if (return_done_i) begin
      // return pops the innermost level
      if (in_high) begin
        in_high <= 1'b0;
      end else begin
        in_low  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pending flags: event or soft set wins over clears
  // ----------------------------------------
  always_comb begin
    next_pending = pending;
    if (wr_pend) begin
      next_pending = next_pending & ~wdata_i[N-1:0];
    end
    if (take_v && hwclr[win]) begin
      next_pending[win] = 1'b0;
    end
    next_pending = next_pending | src_event_i;
    if (wr_pset) begin
      next_pending = next_pending | wdata_i[N-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      primary_en  <= ZERO_RST[7:0];
      extended_en <= ZERO_RST[7:0];
      prio        <= ZERO_RST[N-1:0];
      hwclr       <= HWCLR_RST[N-1:0];
      evt_mask    <= ZERO_RST[EVT_W-1:0];
    end else if (wr_i) begin
      case (addr_i)
        OFS_PRIMARY:  primary_en  <= wdata_i[7:0];
        OFS_EXTENDED: extended_en <= wdata_i[7:0];
        OFS_PRIO:     prio        <= wdata_i[N-1:0];
        OFS_HWCLR:    hwclr       <= wdata_i[N-1:0];
        OFS_EVT_MASK: evt_mask    <= wdata_i[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // sticky events and interrupt line
  // ----------------------------------------
  irq_sticky #(.W(EVT_W)) u_evt (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .set_i   ({return_done_i, take_v}),
    .clr_i   (wr_evt ? wdata_i[EVT_W-1:0] : '0),
    .flag_o  (evt_flags)
  );
  assign irq_o = |(evt_flags & evt_mask);

  // ----------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------
  wire [DATA_W-1:0] state_word = {10'h000, in_high, in_low, 1'b0, 3'(state)};
  wire [DATA_W-1:0] rd_mux =
    (addr_i == OFS_PEND || addr_i == OFS_PSET) ? DATA_W'(pending) :
    (addr_i == OFS_PRIMARY)  ? {8'h00, primary_en}  :
    (addr_i == OFS_EXTENDED) ? {8'h00, extended_en} :
    (addr_i == OFS_PRIO)     ? DATA_W'(prio)        :
    (addr_i == OFS_HWCLR)    ? DATA_W'(hwclr)       :
    (addr_i == OFS_STATE)    ? state_word           :
    (addr_i == OFS_EVT)      ? DATA_W'(evt_flags)   :
    (addr_i == OFS_EVT_MASK) ? DATA_W'(evt_mask)    : '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_no_req_global_off;
    @(posedge clock_i) disable iff (rst_i) !glb_en |-> !irq_req_o;
  endproperty
  a_no_req_global_off: assert property (p_no_req_global_off)
    else $error("request while global enable clear");

  property p_pending_sets;
    @(posedge clock_i) disable iff (rst_i) |src_event_i |=> ((pending & $past(src_event_i)) == $past(src_event_i));
  endproperty
  a_pending_sets: assert property (p_pending_sets)
    else $error("event did not set pending flag");

  property p_call_length;
    @(posedge clock_i) disable iff (rst_i) take_v |=> (state == ST_CALL) [*4] ##1 (state == ST_IDLE);
  endproperty
  a_call_length: assert property (p_call_length)
    else $error("long call length wrong");

  property p_hwclr;
    @(posedge clock_i) disable iff (rst_i)
      take_v && hwclr[win] && !src_event_i[win] && !wr_pset |=> !pending[call_idx];
  endproperty
  a_hwclr: assert property (p_hwclr)
    else $error("flag not cleared on vector");

  property p_no_high_preempt;
    @(posedge clock_i) disable iff (rst_i) in_high && !return_done_i |-> !take_v;
  endproperty
  a_no_high_preempt: assert property (p_no_high_preempt)
    else $error("high routine preempted");

  property p_gap_after_return;
    @(posedge clock_i) disable iff (rst_i) return_done_i |=> !take_v;
  endproperty
  a_gap_after_return: assert property (p_gap_after_return)
    else $error("vector without instruction after return");

  property p_disabled_silent;
    @(posedge clock_i) disable iff (rst_i) (eligible == '0) |-> !irq_req_o;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent)
    else $error("request with no enabled pending source");

  property p_vec_addr;
    @(posedge clock_i) disable iff (rst_i)
      take_v |=> call_o && call_addr_o == VEC_BASE + VEC_W'({call_idx, VEC_STEP_SH'(0)});
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("wrong service address");

  property p_multi_blocks;
    @(posedge clock_i) disable iff (rst_i) instr_end_i && instr_multi_i && !want |-> !take_v;
  endproperty
  a_multi_blocks: assert property (p_multi_blocks)
    else $error("vector after enable clear and multi-cycle instruction");

  c_take_low:  cover property (@(posedge clock_i) take_v && !win_hi);
  c_preempt:   cover property (@(posedge clock_i) take_v && win_hi && in_low);
  c_reenter:   cover property (@(posedge clock_i) return_done_i ##[1:20] take_v);
  c_irq_line:  cover property (@(posedge clock_i) irq_o);
endmodule

// ==== irq_core_model.sv ====
`timescale 1ns/1ps
// core sequencer stand-in: instruction ends, long call, service, return
module irq_core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       call_i,        // vector issued by the controller
  input  wire logic       multi_i,       // next instructions are multi-cycle
  input  wire logic [7:0] ilen_i,        // cycles per instruction
  input  wire logic [7:0] isr_len_i,     // cycles spent in each routine
  output logic            instr_end_o,   // instruction completes
  output logic            instr_multi_o, // kind of the ending instruction
  output logic            return_done_o  // return finished
);
  import irq_ctrl_pkg::*;
  logic [7:0] icnt;   // cycles into the current instruction
  logic [7:0] rcnt;   // cycles left in the running routine
  logic [3:0] depth;  // nesting depth of routines
  logic [2:0] ccnt;   // cycles left in the long call
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one process keeps the nesting count consistent with call and return
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      icnt          <= 8'h00;
      rcnt          <= 8'h00;
      depth         <= 4'h0;
      ccnt          <= 3'h0;
      instr_end_o   <= 1'b0;
      instr_multi_o <= 1'b0;
      return_done_o <= 1'b0;
    end else begin
      instr_end_o   <= 1'b0;
      return_done_o <= 1'b0;
      if (call_i) begin
        ccnt  <= 3'(CALL_CYCLES);
        depth <= depth + 4'h1;
        rcnt  <= isr_len_i;
        icnt  <= 8'h00;
      end else if (ccnt != 3'h0) begin
        // no instruction ends while the call runs
        ccnt <= ccnt - 3'h1;
      end else begin
        icnt <= icnt + 8'h01;
        if (icnt + 8'h01 >= ilen_i) begin
          icnt          <= 8'h00;
          instr_end_o   <= 1'b1;
          instr_multi_o <= multi_i;
        end
        if (depth != 4'h0) begin
          if (rcnt == 8'h00) begin
            return_done_o <= 1'b1;
            depth         <= depth - 4'h1;
            rcnt          <= isr_len_i; // outer routine gets a fresh budget
          end else begin
            rcnt <= rcnt - 8'h01;
          end
        end
      end
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  import irq_ctrl_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [13:0] src_ev  = 14'h0000;
  logic [7:0]  ilen    = 8'h02;
  logic [7:0]  isr_len = 8'h1E;
  logic        multi   = 1'b0;
  logic [15:0] rdata, caddr;
  logic [3:0]  cidx;
  logic        req, call, irq, iend, imulti, rdone;
  int          n_fail   = 0;
  int          compares = 0;
  int          lat, n;
  // reset table: offset and value, last entry unmapped
  logic [3:0]  ra [9] = '{OFS_PEND, OFS_PRIMARY, OFS_EXTENDED, OFS_PRIO, OFS_HWCLR,
                          OFS_STATE, OFS_EVT, OFS_EVT_MASK, 4'hF};
  logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, HWCLR_RST,
                          16'h0001, 16'h0000, 16'h0000, 16'h0000};
  always #2.5 clock_i = ~clock_i;
  irq_ctrl irq_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .src_event_i(src_ev), .instr_end_i(iend),
    .instr_multi_i(imulti), .return_done_i(rdone), .irq_req_o(req), .call_o(call),
    .call_addr_o(caddr), .call_idx_o(cidx), .irq_o(irq));
  irq_core_model irq_core_model_i (.clock_i(clock_i), .rst_i(rst_i), .call_i(call),
    .multi_i(multi), .ilen_i(ilen), .isr_len_i(isr_len), .instr_end_o(iend),
    .instr_multi_o(imulti), .return_done_o(rdone));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string m);
    @(posedge clock_i);
    addr <= a; rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk(rdata, e, m);
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge clock_i);
    src_ev <= m;
    @(posedge clock_i);
    src_ev <= 14'h0000;
  endtask
  // counts vectors seen in a window of c cycles
  task automatic quiet(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(posedge clock_i);
      #1 if (call === 1'b1) k++;
    end
  endtask
  // bounded wait for a vector, then checks its index and address
  task automatic vec(input int lim, input int idx, input string m);
    lat = 0;
    do begin
      @(posedge clock_i);
      #1 lat++;
    end while (lat < lim && call !== 1'b1);
    if (call !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: no vector for %s", $time, m);
      report_and_stop();
    end
    chk({12'h000, cidx}, 16'(idx), m);
    chk(caddr, VEC_BASE + 16'(idx << VEC_STEP_SH), m);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i], "reset value");
    $display("test reset done");
    // flags latch with everything disabled
    pulse(14'h3FFF);
    rchk(OFS_PEND, 16'h3FFF, "pending latched");
    quiet(20, n); chk(16'(n), 16'h0000, "disabled vector");
    wr_reg(OFS_PRIMARY, 16'h007F);
    wr_reg(OFS_EXTENDED, 16'h007F);
    quiet(20, n); chk(16'(n), 16'h0000, "global off vector");
    wr_reg(OFS_PEND, 16'h3FFF);
    rchk(OFS_PEND, 16'h0000, "pending cleared");
    $display("test enables done");
    // fastest response, fixed order, hardware clear, events
    ilen <= 8'h01;
    wr_reg(OFS_EVT_MASK, 16'h0002);
    wr_reg(OFS_PRIMARY, 16'h00FF);
    pulse(14'h0024);
    vec(20, 2, "fixed order");
    // edges after the event edge: detect cycle plus the call_o register edge
    chk(16'(lat), 16'(MIN_RESPONSE - CALL_CYCLES + 1), "response cycles");
    rchk(OFS_PEND, 16'h0020, "hw clear on vector");
    chk({15'h0000, irq}, 16'h0000, "masked event");
    wr_reg(OFS_PEND, 16'h0020);
    quiet(80, n); chk(16'(n), 16'h0000, "no reentry");
    rchk(OFS_EVT, 16'h0003, "events after return");
    chk({15'h0000, irq}, 16'h0001, "event irq");
    wr_reg(OFS_EVT, 16'h0003);
    rchk(OFS_EVT, 16'h0000, "events cleared");
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    $display("test response done");
    // two levels: high first, no preempt of high, high preempts low
    wr_reg(OFS_PRIO, 16'h0020);
    pulse(14'h0024);
    vec(20, 5, "level first");
    quiet(10, n); chk(16'(n), 16'h0000, "high preempted");
    rchk(OFS_STATE, 16'h0021, "in high");
    wr_reg(OFS_PEND, 16'h0020);
    vec(80, 2, "low after high");
    quiet(6, n);
    rchk(OFS_STATE, 16'h0011, "in low");
    pulse(14'h0020);
    vec(20, 5, "high preempts low");
    quiet(6, n);
    rchk(OFS_STATE, 16'h0031, "nested");
    wr_reg(OFS_PEND, 16'h0020);
    quiet(150, n); chk(16'(n), 16'h0000, "after nest");
    $display("test levels done");
    // flag left set at return re-enters
    wr_reg(OFS_PRIO, 16'h0000);
    pulse(14'h0100);
    vec(20, 8, "first entry");
    vec(80, 8, "re-entry");
    wr_reg(OFS_PEND, 16'h0100);
    quiet(100, n); chk(16'(n), 16'h0000, "after re-entry");
    $display("test reentry done");
    // enable cleared mid-instruction, multi-cycle follower
    ilen <= 8'hFF; multi <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      #1 n++;
    end while (n < 600 && iend !== 1'b1);
    if (iend !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: no instruction end", $time);
      report_and_stop();
    end
    pulse(14'h0001);
    // flag latched, detect cycle passed, request stands with no instruction end
    @(posedge clock_i);
    #1 chk({15'h0000, req}, 16'h0001, "request raised");
    wr_reg(OFS_PRIMARY, 16'h007F);
    #1 chk({15'h0000, req}, 16'h0000, "request after global clear");
    quiet(300, n); chk(16'(n), 16'h0000, "vector after clear");
    rchk(OFS_PRIMARY, 16'h007F, "global reads zero");
    rchk(OFS_PEND, 16'h0001, "flag kept");
    $display("test disable race done");
    report_and_stop();
  end
endmodule
